// file: rtl/ecam_disengage.sv
// Cam engage state keeper with disengage timing and cam-area output
`timescale 1ns/100ps
// Contract
// [RULE_01] Software never selects two of 2,4,6
// [RULE_02] Value 1: cam-off input disengages to stop
// [RULE_03] Value 2: travel reaches length, then stop
// [RULE_04] Value 6: like 2, speed kept
// [RULE_05] Value 4: travel exceeds length, back to lead
// [RULE_06] Value 8: clear enable after 1/2/6
// [RULE_07] Value 8 with 4 keeps enable
// [RULE_08] Forced disengage events clear enable
// [RULE_09] Disengage length signed 32-bit, reset zero
// [RULE_10] Start angle sets cam-area output begin
// [RULE_11] End angle sets cam-area output end
// [RULE_12] Status: 0 stop, 1 engaged, 2 lead
// [RULE_13] Value 0 never disengages by itself
module ecam_disengage #(
    parameter int STEP_W = 16
) (
    // Clock and reset
    input wire logic I_CLOCK,
    input wire logic I_RST_N,
    // Parameter access
    input wire logic I_PAR_WR,
    input wire logic I_PAR_RD,
    input wire logic [15:0] I_PAR_ADDR,
    input wire logic [31:0] I_PAR_WDATA,
    output logic [31:0] O_PAR_RDATA,
    // Master axis and engage request
    input wire logic I_MASTER_VALID,
    input wire logic signed [STEP_W-1:0] I_MASTER_STEP,
    input wire logic I_ENGAGE_REQ,
    input wire logic signed [31:0] I_LEAD_LENGTH,
    input wire logic [15:0] I_CAM_ANGLE,
    // Discrete input pin and forced events
    input wire logic I_CAM_OFF,
    input wire ecam_disengage_pkg::force_evt_t I_FORCE,
    // Status outputs
    output logic [1:0] O_ENGAGE_STATE,
    output logic O_CAM_AREA,
    output logic O_KEEP_SPEED
);
    // ----------------------------------------
    // Declarations
    // ----------------------------------------
    ecam_disengage_pkg::cam_state_t state, next_state; // Engage state
    logic [31:0] gear_word, next_gear_word; // Writable settings bits
    logic signed [31:0] dis_length, next_dis_length; // Disengage threshold
    logic [15:0] start_angle, next_start_angle; // Cam-area begin
    logic [15:0] end_angle, next_end_angle; // Cam-area end
    logic signed [31:0] cyc_lead, next_cyc_lead; // Lead length after mode 4
    logic signed [31:0] travel, next_travel, travel_now; // Master travel since entry, and with this step
    logic signed [31:0] lead_target, next_lead_target; // Lead length in use
    logic [2:0] off_sync; // Cam-off pin synchroniser
    logic cam_off_level, next_cam_off_level; // Filtered cam-off level
    logic [31:0] next_rdata;
    logic next_cam_area, next_keep_speed;
    logic [3:0] dis_field; // Disengage field
    logic forced, on_off_pin, on_reach, on_exceed, enabled;

    // Travel has reached (or strictly passed) a signed threshold
    function automatic logic passed(input logic signed [31:0] pos, input logic signed [31:0] lim,
                                    input logic strict);
        if (lim >= 0) begin
            return strict ? (pos > lim) : (pos >= lim);
        end
        return strict ? (pos < lim) : (pos <= lim);
    endfunction

    // ----------------------------------------
    // Cam-off pin synchroniser
    // ----------------------------------------
    // Level counts only once the second and third stages agree
    always_comb begin
        next_cam_off_level = cam_off_level;
        if (off_sync[1] == off_sync[2]) begin
            next_cam_off_level = off_sync[2];
        end
    end

    always_ff @(posedge I_CLOCK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            off_sync <= 3'h0;
            cam_off_level <= 1'b0;
        end else begin
            off_sync <= {off_sync[1:0], I_CAM_OFF};
            cam_off_level <= next_cam_off_level;
        end
    end

    // ----------------------------------------
    // Disengage decisions
    // ----------------------------------------
    always_comb begin
        dis_field = gear_word[ecam_disengage_pkg::DIS_FIELD_LSB +: 4];
        enabled = gear_word[ecam_disengage_pkg::ENABLE_BIT];
        travel_now = travel;
        if (I_MASTER_VALID) begin
            travel_now = travel + 32'(I_MASTER_STEP);
        end
        // RULE_08 forced events
        forced = |I_FORCE;
        // RULE_02 cam-off input
        on_off_pin = dis_field[0] && cam_off_level;
        // RULE_03 RULE_04 reach check; mode 2 and 6 share it, 6 is 2'b11
        on_reach = dis_field[1] && passed(travel_now, dis_length, 1'b0);
        // RULE_05 strict exceed check
        on_exceed = dis_field[2] && !dis_field[1] && passed(travel_now, dis_length, 1'b1);
    end

    // ----------------------------------------
    // State and parameter next values
    // ----------------------------------------
    always_comb begin
        next_state = state;
        next_gear_word = gear_word;
        next_dis_length = dis_length;
        next_start_angle = start_angle;
        next_end_angle = end_angle;
        next_cyc_lead = cyc_lead;
        next_travel = travel_now;
        next_lead_target = lead_target;
        next_keep_speed = 1'b0;
        // Software writes first; hardware clears below override them
        if (I_PAR_WR) begin
            unique case (I_PAR_ADDR)
                ecam_disengage_pkg::ADDR_GEAR_SETTINGS_WORD: begin
                    next_gear_word = I_PAR_WDATA & ecam_disengage_pkg::GEAR_WORD_WMASK;
                end
                // RULE_09 signed threshold register
                ecam_disengage_pkg::ADDR_DISENGAGE_LENGTH: begin
                    next_dis_length = I_PAR_WDATA;
                end
                // RULE_10 RULE_11 angles clipped to full turn
                ecam_disengage_pkg::ADDR_CAM_AREA_START_ANGLE: begin
                    next_start_angle = (I_PAR_WDATA[15:0] > ecam_disengage_pkg::ANGLE_MAX) ?
                                       ecam_disengage_pkg::ANGLE_MAX : I_PAR_WDATA[15:0];
                end
                ecam_disengage_pkg::ADDR_CAM_AREA_END_ANGLE: begin
                    next_end_angle = (I_PAR_WDATA[15:0] > ecam_disengage_pkg::ANGLE_MAX) ?
                                     ecam_disengage_pkg::ANGLE_MAX : I_PAR_WDATA[15:0];
                end
                ecam_disengage_pkg::ADDR_CYCLIC_LEAD_LENGTH: begin
                    next_cyc_lead = I_PAR_WDATA;
                end
                default: ;
            endcase
        end
        if (forced) begin
            // RULE_08 forced disengage, enable cleared
            next_state = ecam_disengage_pkg::ST_STOP;
            next_gear_word[ecam_disengage_pkg::ENABLE_BIT] = 1'b0;
        end else begin
            unique case (state)
                ecam_disengage_pkg::ST_STOP: begin
                    // Engage timing is decided by the neighbouring logic
                    if (enabled && I_ENGAGE_REQ) begin
                        next_state = ecam_disengage_pkg::ST_LEAD;
                        next_travel = '0;
                        next_lead_target = I_LEAD_LENGTH;
                    end
                end
                ecam_disengage_pkg::ST_LEAD: begin
                    if (!enabled) begin
                        next_state = ecam_disengage_pkg::ST_STOP;
                    end else if (passed(travel_now, lead_target, 1'b1)) begin
                        next_state = ecam_disengage_pkg::ST_ENGAGED;
                        next_travel = '0;
                    end
                end
                ecam_disengage_pkg::ST_ENGAGED: begin
                    // RULE_13 field value 0 leaves all three checks low
                    if (!enabled) begin
                        next_state = ecam_disengage_pkg::ST_STOP;
                    end else if (on_exceed) begin
                        // RULE_05 RULE_07 back to lead, enable untouched
                        next_state = ecam_disengage_pkg::ST_LEAD;
                        next_travel = '0;
                        next_lead_target = cyc_lead;
                    end else if (on_off_pin || on_reach) begin
                        // RULE_02 RULE_03 RULE_04 stop state
                        next_state = ecam_disengage_pkg::ST_STOP;
                        next_keep_speed = on_reach && (dis_field[2:1] == 2'h3);
                        // RULE_06 enable cleared after 1, 2 or 6
                        if (dis_field[3]) begin
                            next_gear_word[ecam_disengage_pkg::ENABLE_BIT] = 1'b0;
                        end
                    end
                end
                default: begin
                    next_state = ecam_disengage_pkg::ST_STOP;
                end
            endcase
        end
    end

    // ----------------------------------------
    // Output next values
    // ----------------------------------------
    always_comb begin
        // RULE_10 RULE_11 window wraps through zero when start exceeds end
        if (start_angle <= end_angle) begin
            next_cam_area = (I_CAM_ANGLE >= start_angle) && (I_CAM_ANGLE <= end_angle);
        end else begin
            next_cam_area = (I_CAM_ANGLE >= start_angle) || (I_CAM_ANGLE <= end_angle);
        end
        next_cam_area = next_cam_area && (next_state == ecam_disengage_pkg::ST_ENGAGED);
        next_rdata = '0;
        if (I_PAR_RD) begin
            unique case (I_PAR_ADDR)
                ecam_disengage_pkg::ADDR_GEAR_SETTINGS_WORD: begin
                    next_rdata = gear_word;
                    next_rdata[ecam_disengage_pkg::STATUS_LSB +: 2] = O_ENGAGE_STATE;
                end
                ecam_disengage_pkg::ADDR_DISENGAGE_LENGTH: next_rdata = dis_length;
                ecam_disengage_pkg::ADDR_CAM_AREA_START_ANGLE: next_rdata = {16'h0, start_angle};
                ecam_disengage_pkg::ADDR_CAM_AREA_END_ANGLE: next_rdata = {16'h0, end_angle};
                ecam_disengage_pkg::ADDR_CYCLIC_LEAD_LENGTH: next_rdata = cyc_lead;
                default: next_rdata = '0;
            endcase
        end
    end

    // ----------------------------------------
    // Registers
    // ----------------------------------------
    always_ff @(posedge I_CLOCK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            state <= ecam_disengage_pkg::ST_STOP;
            gear_word <= ecam_disengage_pkg::GEAR_WORD_RESET;
            dis_length <= ecam_disengage_pkg::DISENGAGE_LENGTH_RESET;
            start_angle <= ecam_disengage_pkg::ANGLE_RESET;
            end_angle <= ecam_disengage_pkg::ANGLE_RESET;
            cyc_lead <= ecam_disengage_pkg::CYCLIC_LEAD_RESET;
            travel <= '0;
            lead_target <= '0;
            O_PAR_RDATA <= '0;
            O_ENGAGE_STATE <= ecam_disengage_pkg::STATUS_STOP;
            O_CAM_AREA <= 1'b0;
            O_KEEP_SPEED <= 1'b0;
        end else begin
            state <= next_state;
            gear_word <= next_gear_word;
            dis_length <= next_dis_length;
            start_angle <= next_start_angle;
            end_angle <= next_end_angle;
            cyc_lead <= next_cyc_lead;
            travel <= next_travel;
            lead_target <= next_lead_target;
            O_PAR_RDATA <= next_rdata;
            // RULE_12 status code from the next state
            O_ENGAGE_STATE <= (next_state == ecam_disengage_pkg::ST_ENGAGED) ? ecam_disengage_pkg::STATUS_ENGAGED :
                              (next_state == ecam_disengage_pkg::ST_LEAD) ? ecam_disengage_pkg::STATUS_LEAD :
                              ecam_disengage_pkg::STATUS_STOP;
            O_CAM_AREA <= next_cam_area;
            O_KEEP_SPEED <= next_keep_speed;
        end
    end

    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    AST_FORCE_STOP: assert property (@(posedge I_CLOCK) disable iff (!I_RST_N) // RULE_08
        forced |=> (state == ecam_disengage_pkg::ST_STOP) && !gear_word[ecam_disengage_pkg::ENABLE_BIT])
        else $error("forced event did not stop and clear enable");
    AST_OFF_PIN: assert property (@(posedge I_CLOCK) disable iff (!I_RST_N) // RULE_02
        (state == ecam_disengage_pkg::ST_ENGAGED && dis_field[0] && cam_off_level && !on_exceed)
        |=> state == ecam_disengage_pkg::ST_STOP)
        else $error("cam-off input did not disengage");
    AST_REACH: assert property (@(posedge I_CLOCK) disable iff (!I_RST_N) // RULE_03
        (state == ecam_disengage_pkg::ST_ENGAGED && !forced && dis_field[2:1] == 2'h1 && enabled
         && passed(travel_now, dis_length, 1'b0)) |=> state == ecam_disengage_pkg::ST_STOP)
        else $error("reach of disengage length did not stop");
    AST_KEEP_SPEED: assert property (@(posedge I_CLOCK) disable iff (!I_RST_N) // RULE_04
        O_KEEP_SPEED |-> $past(dis_field[2:1]) == 2'h3 && O_ENGAGE_STATE == ecam_disengage_pkg::STATUS_STOP)
        else $error("speed hold outside mode 6 stop");
    AST_EXCEED_LEAD: assert property (@(posedge I_CLOCK) disable iff (!I_RST_N) // RULE_05
        (state == ecam_disengage_pkg::ST_ENGAGED && !forced && enabled && on_exceed)
        |=> state == ecam_disengage_pkg::ST_LEAD && lead_target == $past(cyc_lead) && travel == 0)
        else $error("exceed did not return to lead");
    AST_CLEAR_ENABLE: assert property (@(posedge I_CLOCK) disable iff (!I_RST_N) // RULE_06
        (state == ecam_disengage_pkg::ST_ENGAGED && enabled && dis_field[3] && (on_off_pin || on_reach)
         && !on_exceed) |=> !gear_word[ecam_disengage_pkg::ENABLE_BIT])
        else $error("enable not cleared after disengage");
    AST_KEEP_ENABLE: assert property (@(posedge I_CLOCK) disable iff (!I_RST_N) // RULE_07
        (state == ecam_disengage_pkg::ST_ENGAGED && enabled && on_exceed && !forced && !I_PAR_WR)
        |=> gear_word[ecam_disengage_pkg::ENABLE_BIT])
        else $error("enable lost on return to lead");
    AST_STATUS_CODE: assert property (@(posedge I_CLOCK) disable iff (!I_RST_N) // RULE_12
        ##1 (O_ENGAGE_STATE == ecam_disengage_pkg::STATUS_ENGAGED) == (state == ecam_disengage_pkg::ST_ENGAGED)
        && (O_ENGAGE_STATE == ecam_disengage_pkg::STATUS_LEAD) == (state == ecam_disengage_pkg::ST_LEAD))
        else $error("status code does not match state");
    AST_NO_SELF_DIS: assert property (@(posedge I_CLOCK) disable iff (!I_RST_N) // RULE_13
        (state == ecam_disengage_pkg::ST_ENGAGED && dis_field == 4'h0 && !forced && enabled && !I_PAR_WR)
        |=> state == ecam_disengage_pkg::ST_ENGAGED)
        else $error("disengaged with field value 0");
    AST_AREA_ENGAGED: assert property (@(posedge I_CLOCK) disable iff (!I_RST_N) // RULE_10
        O_CAM_AREA |-> O_ENGAGE_STATE == ecam_disengage_pkg::STATUS_ENGAGED)
        else $error("cam-area active while not engaged");
endmodule

// file: rtl/ecam_disengage_pkg.sv
// Package of constants and types for the cam disengage controller
package ecam_disengage_pkg;
    // ----------------------------------------
    // Parameter addresses (word addresses)
    // ----------------------------------------
    localparam logic [15:0] ADDR_GEAR_SETTINGS_WORD = 16'h05b0;
    localparam logic [15:0] ADDR_DISENGAGE_LENGTH = 16'h05b2;
    localparam logic [15:0] ADDR_CAM_AREA_START_ANGLE = 16'h05b4;
    localparam logic [15:0] ADDR_CAM_AREA_END_ANGLE = 16'h05b6;
    localparam logic [15:0] ADDR_CYCLIC_LEAD_LENGTH = 16'h05b8;

    // ----------------------------------------
    // Field positions in the gear settings word
    // ----------------------------------------
    localparam int ENABLE_BIT = 0;
    localparam int DIS_FIELD_LSB = 12;
    localparam int STATUS_LSB = 28;

    // ----------------------------------------
    // Reset values and limits
    // ----------------------------------------
    localparam logic [31:0] GEAR_WORD_RESET = 32'h0000_0000;
    localparam logic [31:0] GEAR_WORD_WMASK = 32'h00ff_ffff;
    localparam logic [31:0] DISENGAGE_LENGTH_RESET = 32'h0000_0000;
    localparam logic [15:0] ANGLE_RESET = 16'h0000;
    localparam logic [15:0] ANGLE_MAX = 16'h0168;
    localparam logic [31:0] CYCLIC_LEAD_RESET = 32'h0000_0000;
    localparam logic [7:0] CAM_AREA_DO_CODE = 8'h18;

    // ----------------------------------------
    // Engage states, Gray along stop-lead-engaged
    // ----------------------------------------
    typedef enum logic [1:0] {
        ST_STOP = 2'h0,
        ST_LEAD = 2'h1,
        ST_ENGAGED = 2'h3
    } cam_state_t;

    // Status codes shown in the read-only field
    localparam logic [1:0] STATUS_STOP = 2'h0;
    localparam logic [1:0] STATUS_ENGAGED = 2'h1;
    localparam logic [1:0] STATUS_LEAD = 2'h2;

    // Events that force a disengage
    typedef struct packed {
        logic servo_off;
        logic servo_fault;
        logic limit_fwd;
        logic limit_rev;
        logic homing;
    } force_evt_t;
endpackage

// file: testbench/master_axis_source.sv
// Model of the master axis pulse source feeding the cam block
`timescale 1ns/100ps
module master_axis_source (
    // Clock
    input wire logic i_clock,
    // Step stream towards the cam block
    output logic o_valid,
    output logic signed [15:0] o_step
);
    // Idle lines carry no data; start from a pattern, not zero
    initial begin
        o_valid = 1'b0;
        o_step = 16'h5a5a;
    end
    // One step, after some idle cycles so the source can be slow or prompt
    task automatic send(input logic signed [15:0] s, input int gap);
        repeat (gap) @(posedge i_clock);
        o_valid <= 1'b1;
        o_step <= s;
        @(posedge i_clock);
        o_valid <= 1'b0;
        // Released data is inverted so a stale step never looks valid
        o_step <= ~s;
    endtask
endmodule

// file: testbench/electronic_cam_disengage_control_bench.sv
// Self-checking bench for the cam disengage controller
`timescale 1ns/100ps
module electronic_cam_disengage_control_bench;
    // ----------------------------------------
    // Signals
    // ----------------------------------------
    logic clock = 1'b0;
    logic rst_n = 1'b0;
    logic par_wr = 1'b0;
    logic par_rd = 1'b0;
    logic [15:0] par_addr = 16'h0000;
    logic [31:0] par_wdata = 32'h0000_0000;
    logic [31:0] par_rdata;
    logic m_valid;
    logic signed [15:0] m_step;
    logic engage_req = 1'b0;
    logic signed [31:0] lead_len = 32'sh0;
    logic [15:0] cam_angle = 16'h005a;
    logic cam_off = 1'b0;
    ecam_disengage_pkg::force_evt_t force_evt = '0;
    logic [1:0] engage_state;
    logic cam_area;
    logic keep_speed;
    int miscompares = 0;
    int compares = 0;
    // Reference model state: status code, travel, enable, field, lengths
    int mst = 0;
    int trav = 0;
    int en = 0;
    int u = 0;
    int len = 0;
    int llen = 0;
    int cyc = 4;
    // Cam-area window bounds as stored, after clipping
    int sa = 0;
    int ea = 0;

    always #10 clock = ~clock;

    ecam_disengage dut (.I_CLOCK(clock), .I_RST_N(rst_n), .I_PAR_WR(par_wr), .I_PAR_RD(par_rd),
        .I_PAR_ADDR(par_addr), .I_PAR_WDATA(par_wdata), .O_PAR_RDATA(par_rdata), .I_MASTER_VALID(m_valid),
        .I_MASTER_STEP(m_step), .I_ENGAGE_REQ(engage_req), .I_LEAD_LENGTH(lead_len), .I_CAM_ANGLE(cam_angle),
        .I_CAM_OFF(cam_off), .I_FORCE(force_evt), .O_ENGAGE_STATE(engage_state), .O_CAM_AREA(cam_area),
        .O_KEEP_SPEED(keep_speed));
    master_axis_source u_src (.i_clock(clock), .o_valid(m_valid), .o_step(m_step));

    // ----------------------------------------
    // Shared tasks
    // ----------------------------------------
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            miscompares++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic finish_test();
        $display("compares %0d miscompares %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    // Parameter write: one-cycle strobe
    task automatic wr(input logic [15:0] a, input logic [31:0] d);
        @(posedge clock);
        par_wr <= 1'b1;
        par_addr <= a;
        par_wdata <= d;
        @(posedge clock);
        par_wr <= 1'b0;
    endtask
    // Parameter read: data stands one cycle after the read edge
    task automatic rd(input logic [15:0] a, output logic [31:0] d);
        @(posedge clock);
        par_rd <= 1'b1;
        par_addr <= a;
        @(posedge clock);
        par_rd <= 1'b0;
        #1 d = par_rdata;
    endtask
    // One master step, then the model decides the expected state
    task automatic step(input int s);
        int prev;
        int m;
        int keep;
        int a;
        int win;
        prev = mst;
        m = u & 6;
        keep = 0;
        // Random cam angle, so both window edges get crossed
        a = $urandom % 361;
        win = (sa <= ea) ? (a >= sa && a <= ea) : (a >= sa || a <= ea);
        cam_angle <= a[15:0];
        u_src.send(s[15:0], $urandom % 3);
        trav += s;
        if (mst == 2 && (llen >= 0 ? trav > llen : trav < llen)) begin
            mst = 1;
            trav = 0;
        end else if (mst == 1 && m == 4 && (len >= 0 ? trav > len : trav < len)) begin
            mst = 2;
            trav = 0;
            llen = cyc;
        end else if (mst == 1 && m != 0 && m != 4 && (len >= 0 ? trav >= len : trav <= len)) begin
            mst = 0;
            keep = (m == 6);
            if (u & 8) en = 0;
        end
        #1;
        check(engage_state, mst);
        check(keep_speed, keep);
        if (prev == mst) check(cam_area, mst == 1 && win != 0);
    endtask
    // Enable with a disengage field value, engage and move the master
    task automatic run(input int uu, input int ln, input int dir);
        logic [31:0] r;
        int n;
        lead_len <= (dir < 0) ? -32'sd2 : 32'sd3;
        llen = (dir < 0) ? -2 : 3;
        wr(ecam_disengage_pkg::ADDR_DISENGAGE_LENGTH, ln);
        len = ln;
        // never two of 2, 4, 6
        wr(ecam_disengage_pkg::ADDR_GEAR_SETTINGS_WORD, {16'h0000, uu[3:0], 12'h001});
        u = uu;
        en = 1;
        @(posedge clock);
        engage_req <= 1'b1;
        @(posedge clock);
        engage_req <= 1'b0;
        mst = 2;
        trav = 0;
        #1 check(engage_state, 2);
        for (n = 0; n < 40 && mst != 0; n++) step(dir * (1 + $urandom % 3));
        if (uu[0]) begin
            // Cam-off pin goes through a synchroniser, so poll a bounded time
            cam_off <= 1'b1;
            for (n = 0; n < 10 && engage_state !== 2'h0; n++) @(posedge clock);
            cam_off <= 1'b0;
            mst = 0;
            if (u & 8) en = 0;
            #1 check(engage_state, mst);
        end
        rd(ecam_disengage_pkg::ADDR_GEAR_SETTINGS_WORD, r);
        check(r[0], en);
        check(r[29:28], mst);
        // Clearing the enable also returns to stop
        wr(ecam_disengage_pkg::ADDR_GEAR_SETTINGS_WORD, 32'h0000_0000);
        repeat (2) @(posedge clock);
        mst = 0;
        #1 check(engage_state, 0);
    endtask

    // ----------------------------------------
    // Watchdog and main sequence
    // ----------------------------------------
    initial begin
        // About 20000 cycles, many times the longest expected sequence
        #400_000;
        miscompares++;
        finish_test();
    end
    initial begin
        logic [31:0] r;
        static logic [15:0] addrs[5] = '{16'h05b0, 16'h05b2, 16'h05b4, 16'h05b6, 16'h0000};
        void'($urandom(32'h7db8));
        repeat (12) @(posedge clock);
        rst_n <= 1'b1;
        // Reset values, plus an unmapped address reading zero
        foreach (addrs[i]) begin
            rd(addrs[i], r);
            check(r, 32'h0000_0000);
        end
        wr(ecam_disengage_pkg::ADDR_GEAR_SETTINGS_WORD, 32'hff00_0000);
        rd(ecam_disengage_pkg::ADDR_GEAR_SETTINGS_WORD, r);
        check(r, 32'h0000_0000);
        // Window 100..360; an oversized end angle is clipped
        wr(ecam_disengage_pkg::ADDR_CAM_AREA_END_ANGLE, 32'h0000_0190);
        rd(ecam_disengage_pkg::ADDR_CAM_AREA_END_ANGLE, r);
        check(r, 32'h0000_0168);
        wr(ecam_disengage_pkg::ADDR_CAM_AREA_START_ANGLE, 32'h0000_0064);
        rd(ecam_disengage_pkg::ADDR_CAM_AREA_START_ANGLE, r);
        check(r, 32'h0000_0064);
        sa = 100;
        ea = 360;
        wr(ecam_disengage_pkg::ADDR_CYCLIC_LEAD_LENGTH, 32'h0000_0004);
        run(2, 10, 1);
        run(6, 7, 1);
        run(10, 5, 1);
        run(14, 4, 1);
        run(12, 6, 1);
        run(4, 8, 1);
        // Wrapping window: start above end
        wr(ecam_disengage_pkg::ADDR_CAM_AREA_END_ANGLE, 32'h0000_0032);
        ea = 50;
        run(2, -5, -1);
        run(0, 5, 1);
        run(9, 5, 1);
        run(1, 5, 1);
        // Each forced event disengages and clears the enable
        for (int i = 0; i < 5; i++) begin
            wr(ecam_disengage_pkg::ADDR_GEAR_SETTINGS_WORD, 32'h0000_0001);
            @(posedge clock);
            engage_req <= 1'b1;
            @(posedge clock);
            engage_req <= 1'b0;
            force_evt <= ecam_disengage_pkg::force_evt_t'(5'b00001 << i);
            repeat (2) @(posedge clock);
            force_evt <= '0;
            #1 check(engage_state, 0);
            rd(ecam_disengage_pkg::ADDR_GEAR_SETTINGS_WORD, r);
            check(r[0], 0);
        end
        finish_test();
    end
endmodule
